//--- logic/scpc_pkg.sv
// Shared constants, types and decode helpers for the serial controller register front end
package scpc_pkg;

    // Register file geometry
    localparam int unsigned REG_COUNT  = 16;   // Locations per channel
    localparam int unsigned PTR_W      = 4;    // Pointer width incl. high bit
    localparam int unsigned CHAN_COUNT = 2;    // Channels B (0) and A (1)
    localparam logic        CH_A       = 1'b1; // Channel A index
    localparam logic        CH_B       = 1'b0; // Channel B index

    // Register locations
    localparam logic [3:0] IDX_CMD    = 4'h0; // Command / pointer register
    localparam logic [3:0] IDX_INTDMA = 4'h1; // Interrupt/DMA control
    localparam logic [3:0] IDX_VECTOR = 4'h2; // Shared vector register
    localparam logic [3:0] IDX_WR3    = 4'h3; // Receive parameters
    localparam logic [3:0] IDX_WR4    = 4'h4; // Mode register
    localparam logic [3:0] IDX_WR5    = 4'h5; // Transmit parameters
    localparam logic [3:0] IDX_LOC6   = 4'h6; // Byte count low location
    localparam logic [3:0] IDX_LOC7   = 4'h7; // Sync / auxiliary location
    localparam logic [3:0] IDX_DATA   = 4'h8; // Data location
    localparam logic [3:0] IDX_MASTER = 4'h9; // Shared master control
    localparam logic [3:0] IDX_WR10   = 4'hA; // Misc control
    localparam logic [3:0] IDX_LOC11  = 4'hB; // Clock mode location
    localparam logic [3:0] IDX_LOC12  = 4'hC; // Time constant low
    localparam logic [3:0] IDX_LOC13  = 4'hD; // Time constant high
    localparam logic [3:0] IDX_LOC14  = 4'hE; // Misc / auxiliary image
    localparam logic [3:0] IDX_EXTINT = 4'hF; // Extended int control

    // Command register fields
    localparam int unsigned CMD_PTR_LSB   = 0; // Pointer bits 2..0
    localparam int unsigned CMD_FIELD_LSB = 3; // Command bits 5..3
    localparam int unsigned CMD_CRC_LSB   = 6; // CRC command bits 7..6

    // CRC command codes
    localparam logic [1:0] CRC_NULL    = 2'h0;
    localparam logic [1:0] CRC_RX_CHK  = 2'h1;
    localparam logic [1:0] CRC_TX_GEN  = 2'h2;
    localparam logic [1:0] CRC_TX_URUN = 2'h3;

    // Command field codes
    localparam logic [2:0] CMD_NULL      = 3'h0;
    localparam logic [2:0] CMD_POINT_HI  = 3'h1;
    localparam logic [2:0] CMD_EXT_RST   = 3'h2;
    localparam logic [2:0] CMD_ABORT     = 3'h3;
    localparam logic [2:0] CMD_RX_NEXT   = 3'h4;
    localparam logic [2:0] CMD_TX_PEND   = 3'h5;
    localparam logic [2:0] CMD_ERR_RST   = 3'h6;
    localparam logic [2:0] CMD_SVC_RST   = 3'h7;

    // Option bits in other registers
    localparam int unsigned EXTINT_FIFO_BIT   = 2; // Status FIFO enable
    localparam int unsigned EXTINT_AUXSEL_BIT = 0; // Location 7 reaches aux reg
    localparam int unsigned AUX_EXTRD_BIT     = 6; // Extended read enable
    localparam int unsigned MODE_LSB          = 4; // Sync mode field in mode reg
    localparam logic [1:0]  MODE_SDLC         = 2'h2;

    // Values after reset
    localparam logic [7:0] CMD_RST    = 8'h00;
    localparam logic [7:0] INTDMA_RST = 8'h00;
    localparam logic [7:0] WREG_RST   = 8'h00;
    localparam logic [3:0] PTR_RST    = 4'h0;

    // One-cycle command strobes for one channel
    typedef struct packed {
        logic crcCheckRst;   // Reset receive CRC checker
        logic txCrcGenRst;   // Reset transmit CRC generator
        logic txUnderrunRst; // Reset underrun/end_of_message latch
        logic extStatRst;    // Re-arm external/status latches
        logic sendAbort;     // Send abort sequence
        logic rxIntNextEn;   // Interrupt on next received character
        logic txIntPendRst;  // Clear transmit interrupt pending
        logic errorRst;      // Clear latched receive errors
        logic highestSvcRst; // Clear highest interrupt_under_service
    } scpc_cmd_t;

    // Interrupt/DMA control register fields, bit 7 first
    typedef struct packed {
        logic       dmaReqEn;        // Wait/request pin enable
        logic       dmaReqFunc;      // 1 = request, 0 = wait
        logic       dmaReqDir;       // 1 = receive, 0 = transmit
        logic [1:0] rxIntMode;       // Receive interrupt mode
        logic       parityIsSpecial; // Parity error is special condition
        logic       txIntEn;         // Transmit interrupt enable
        logic       extIntEn;        // External interrupt enable
    } scpc_intdma_t;

    // Read registers supplied by the channel logic
    typedef struct packed {
        logic [7:0] rr0;  // Tx/Rx buffer and external status
        logic [7:0] rr1;  // Special receive condition status
        logic [7:0] rr2;  // Vector image
        logic [7:0] rr3;  // Interrupt pending bits
        logic [7:0] byteCountLowRead; // Frame count low
        logic [7:0] byteCountHighRead; // Frame count high
        logic [7:0] rr8;  // Receive data
        logic [7:0] rr10; // Misc status
        logic [7:0] rr12; // Time constant low image
        logic [7:0] timeConstantHighRead; // Time const high
        logic [7:0] rr14; // Misc image
        logic [7:0] extIntControlRead; // Ext int image
    } scpc_rdset_t;

    // Locations that both channels share
    function automatic logic scpc_is_shared(input logic [3:0] idx);
        return (idx == IDX_VECTOR) || (idx == IDX_MASTER);
    endfunction

endpackage

//--- logic/scpc_cmd_decode.sv
// Command register decoder: turns a command byte into per-channel strobes
`timescale 1ns/10ps
`default_nettype none
module scpc_cmd_decode
    import scpc_pkg::*;
(
    input  wire logic       cmdValid,  // Command byte written this cycle
    input  wire logic [7:0] cmdByte,   // Byte written at location zero
    input  wire logic       sdlcMode,  // Channel runs bit-oriented protocol
    output scpc_cmd_t       cmdPulse,  // Decoded strobes, combinational
    output logic            pointHigh  // Next access goes to upper bank
);

    logic [1:0] crcCode;  // CRC command field
    logic [2:0] cmdCode;  // Main command field

    assign crcCode = cmdByte[CMD_CRC_LSB +: 2];
    assign cmdCode = cmdByte[CMD_FIELD_LSB +: 3];

    // Both fields act in the same write; they never collide
    always_comb begin
        cmdPulse  = '0;
        pointHigh = 1'b0;
        if (cmdValid) begin
            case (crcCode)
                CRC_RX_CHK:  cmdPulse.crcCheckRst   = 1'b1;
                CRC_TX_GEN:  cmdPulse.txCrcGenRst   = 1'b1;
                CRC_TX_URUN: cmdPulse.txUnderrunRst = 1'b1;
                default: ;
            endcase
            case (cmdCode)
                CMD_POINT_HI: pointHigh              = 1'b1;
                CMD_EXT_RST:  cmdPulse.extStatRst    = 1'b1;
                CMD_ABORT:    cmdPulse.sendAbort     = sdlcMode;
                CMD_RX_NEXT:  cmdPulse.rxIntNextEn   = 1'b1;
                CMD_TX_PEND:  cmdPulse.txIntPendRst  = 1'b1;
                CMD_ERR_RST:  cmdPulse.errorRst      = 1'b1;
                CMD_SVC_RST:  cmdPulse.highestSvcRst = 1'b1;
                default: ;
            endcase
        end
    end

endmodule
`default_nettype wire

//--- logic/scpc_read_mux.sv
// Read location multiplexer with image aliasing and option swaps
`timescale 1ns/10ps
`default_nettype none
module scpc_read_mux
    import scpc_pkg::*;
(
    input  wire logic [3:0]             rdIdx,   // Location being read
    input  wire scpc_rdset_t            rdSet,   // Read registers of channel
    input  wire logic [15:0][7:0]       wrRegs,  // Write registers of channel
    input  wire logic [7:0]             auxReg,  // auxiliary_feature_reg
    input  wire logic                   fifoEn,  // Status FIFO enabled
    input  wire logic                   extRdEn, // Extended read enabled
    output logic [7:0]                  rdByte   // Selected byte
);

    // Pure lookup; the caller registers the result
    always_comb begin
        case (rdIdx)
            IDX_CMD:    rdByte = rdSet.rr0;
            IDX_INTDMA: rdByte = rdSet.rr1;
            IDX_VECTOR: rdByte = rdSet.rr2;
            IDX_WR3:    rdByte = rdSet.rr3;
            IDX_WR4:    rdByte = extRdEn ? wrRegs[IDX_WR4] : rdSet.rr0;
            IDX_WR5:    rdByte = extRdEn ? wrRegs[IDX_WR5] : rdSet.rr1;
            IDX_LOC6:   rdByte = fifoEn ? rdSet.byteCountLowRead : rdSet.rr2;
            IDX_LOC7:   rdByte = fifoEn ? rdSet.byteCountHighRead : rdSet.rr3;
            IDX_DATA:   rdByte = rdSet.rr8;
            IDX_MASTER: rdByte = extRdEn ? wrRegs[IDX_WR3] : rdSet.timeConstantHighRead;
            IDX_WR10:   rdByte = rdSet.rr10;
            IDX_LOC11:  rdByte = extRdEn ? wrRegs[IDX_WR10] : rdSet.extIntControlRead;
            IDX_LOC12:  rdByte = rdSet.rr12;
            IDX_LOC13:  rdByte = rdSet.timeConstantHighRead;
            IDX_LOC14:  rdByte = extRdEn ? auxReg : rdSet.rr14;
            default:    rdByte = rdSet.extIntControlRead;
        endcase
    end

endmodule
`default_nettype wire

//--- logic/scpc_regs.sv
// Pointer, command and write register front end of the two-channel serial controller
`timescale 1ns/10ps
`default_nettype none
module scpc_regs
    import scpc_pkg::*;
(
    input  wire logic             mclk,         // Host bus clock, 250 MHz
    input  wire logic             reset_n,      // Hardware reset, async
    input  wire logic             hostWr,       // Write strobe, one cycle
    input  wire logic             hostRd,       // Read strobe, one cycle
    input  wire logic             hostChanA,    // High = channel A, low = B
    input  wire logic             hostDataSel,  // High = data location direct
    input  wire logic [7:0]       hostWrData,   // Write data
    input  wire scpc_rdset_t      rdSetA,       // Channel A read registers
    input  wire scpc_rdset_t      rdSetB,       // Channel B read registers
    output logic [7:0]            hostRdData,   // Read data, registered
    output logic                  hostRdValid,  // Read data valid pulse
    output logic [3:0]            regPointer,   // Current pointer
    output logic [15:0][7:0]      wrRegsA,      // Channel A write registers
    output logic [15:0][7:0]      wrRegsB,      // Channel B write registers
    output logic [7:0]            auxRegA,      // Channel A aux feature reg
    output logic [7:0]            auxRegB,      // Channel B aux feature reg
    output scpc_intdma_t          intDmaCtlA,   // Channel A int/DMA fields
    output scpc_intdma_t          intDmaCtlB,   // Channel B int/DMA fields
    output logic                  dataWrStrobe, // Data location written
    output logic                  dataWrChanA,  // Channel of that data write
    output scpc_cmd_t             cmdA,         // Channel A command strobes
    output scpc_cmd_t             cmdB          // Channel B command strobes
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------

    // Per-channel write registers; shared slots unused here
    logic [CHAN_COUNT-1:0][REG_COUNT-1:0][7:0] chanRegs_ff;
    logic [CHAN_COUNT-1:0][REG_COUNT-1:0][7:0] nxt_chanRegs;
    // Vector and master control live once for both channels
    logic [7:0]                                vectorReg_ff;
    logic [7:0]                                nxt_vectorReg;
    logic [7:0]                                masterReg_ff;
    logic [7:0]                                nxt_masterReg;
    // Auxiliary feature register per channel
    logic [CHAN_COUNT-1:0][7:0]                auxReg_ff;
    logic [CHAN_COUNT-1:0][7:0]                nxt_auxReg;

    // Pointer: bit 3 is the point-high extension
    logic [PTR_W-1:0]                          ptr_ff;
    logic [PTR_W-1:0]                          nxt_ptr;

    // Read result and its valid flag
    logic [7:0]                                rdData_ff;
    logic [7:0]                                nxt_rdData;
    logic                                      rdValid_ff;
    logic                                      nxt_rdValid;

    // Data location write strobe
    logic                                      dataWr_ff;
    logic                                      nxt_dataWr;
    logic                                      dataWrChan_ff;
    logic                                      nxt_dataWrChan;

    // Command strobes, registered so they are clean pulses
    scpc_cmd_t [CHAN_COUNT-1:0]                cmd_ff;
    scpc_cmd_t [CHAN_COUNT-1:0]                nxt_cmd;

    // ------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------

    logic                   chanSel;    // Channel addressed now
    logic [3:0]             accIdx;     // Location addressed now
    logic                   cmdWrite;   // Write lands on command location
    logic [CHAN_COUNT-1:0]  cmdValid;   // Per-channel command write
    logic [CHAN_COUNT-1:0]  ptHighReq;  // Point-high seen per channel
    scpc_cmd_t [CHAN_COUNT-1:0] cmdDec; // Decoded strobes per channel
    logic [CHAN_COUNT-1:0][7:0] rdMux;  // Read byte per channel
    logic [CHAN_COUNT-1:0][15:0][7:0] wrView; // Registers seen by a channel

    // Channel A on high select, B on low
    assign chanSel = hostChanA ? CH_A : CH_B;

    // Data select bypasses the pointer, otherwise the pointer decides
    assign accIdx = hostDataSel ? IDX_DATA : ptr_ff;

    // A control write at pointer zero is a command
    assign cmdWrite = hostWr && !hostDataSel && (ptr_ff == PTR_RST);

    // ------------------------------------------------------------------
    // Per-channel decode and read path
    // ------------------------------------------------------------------

    generate
        for (genvar ch = 0; ch < CHAN_COUNT; ch++) begin : g_chan
            logic sdlcMode; // Bit-oriented link mode from mode register
            logic fifoEn;   // Status FIFO option
            logic extRdEn;  // Extended read option

            assign sdlcMode = (chanRegs_ff[ch][IDX_WR4][MODE_LSB +: 2] == MODE_SDLC);
            assign fifoEn   = chanRegs_ff[ch][IDX_EXTINT][EXTINT_FIFO_BIT];
            assign extRdEn  = auxReg_ff[ch][AUX_EXTRD_BIT];
            assign cmdValid[ch] = cmdWrite && (chanSel == ch[0]);

            // Shared registers appear in both channel views
            always_comb begin
                wrView[ch]             = chanRegs_ff[ch];
                wrView[ch][IDX_VECTOR] = vectorReg_ff;
                wrView[ch][IDX_MASTER] = masterReg_ff;
            end

            scpc_cmd_decode u_dec (
                .cmdValid  (cmdValid[ch]),
                .cmdByte   (hostWrData),
                .sdlcMode  (sdlcMode),
                .cmdPulse  (cmdDec[ch]),
                .pointHigh (ptHighReq[ch])
            );

            scpc_read_mux u_rd (
                .rdIdx   (accIdx),
                .rdSet   ((ch == 1) ? rdSetA : rdSetB),
                .wrRegs  (wrView[ch]),
                .auxReg  (auxReg_ff[ch]),
                .fifoEn  (fifoEn),
                .extRdEn (extRdEn),
                .rdByte  (rdMux[ch])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Pointer next state
    // ------------------------------------------------------------------

    // Pointer returns to zero after one control access elsewhere
    always_comb begin
        nxt_ptr = ptr_ff;
        if (cmdWrite) begin
            // Load low bits; point high adds the upper bank
            nxt_ptr = {ptHighReq[chanSel], hostWrData[CMD_PTR_LSB +: 3]};
        end else if ((hostWr || hostRd) && !hostDataSel && (ptr_ff != PTR_RST)) begin
            nxt_ptr = PTR_RST;
        end
    end

    // ------------------------------------------------------------------
    // Write register next state
    // ------------------------------------------------------------------

    // Writes go to shared, auxiliary or per-channel storage
    always_comb begin
        nxt_chanRegs   = chanRegs_ff;
        nxt_vectorReg  = vectorReg_ff;
        nxt_masterReg  = masterReg_ff;
        nxt_auxReg     = auxReg_ff;
        nxt_dataWr     = 1'b0;
        nxt_dataWrChan = dataWrChan_ff;
        if (hostWr) begin
            if (scpc_is_shared(accIdx)) begin
                // One copy serves both channels
                if (accIdx == IDX_VECTOR) begin
                    nxt_vectorReg = hostWrData;
                end else begin
                    nxt_masterReg = hostWrData;
                end
            end else if ((accIdx == IDX_LOC7) &&
                         chanRegs_ff[chanSel][IDX_EXTINT][EXTINT_AUXSEL_BIT]) begin
                // Location 7 is redirected to the auxiliary register
                nxt_auxReg[chanSel] = hostWrData;
            end else begin
                // Ordinary per-channel register, command byte included
                nxt_chanRegs[chanSel][accIdx] = hostWrData;
            end
            if (accIdx == IDX_DATA) begin
                // Data byte is handed on to the transmitter
                nxt_dataWr     = 1'b1;
                nxt_dataWrChan = chanSel;
            end
        end
    end

    // ------------------------------------------------------------------
    // Command strobes and read data next state
    // ------------------------------------------------------------------

    // Strobes last exactly one cycle after the command write
    always_comb begin
        nxt_cmd = cmdDec;
    end

    // Read data is captured on the strobe and held until the next read
    always_comb begin
        nxt_rdData  = rdData_ff;
        nxt_rdValid = hostRd;
        if (hostRd) begin
            nxt_rdData = rdMux[chanSel];
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------

    // All state; write registers clear so the outputs are known
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int ch = 0; ch < CHAN_COUNT; ch++) begin
                for (int r = 0; r < REG_COUNT; r++) begin
                    chanRegs_ff[ch][r] <= WREG_RST;
                end
                chanRegs_ff[ch][IDX_CMD]    <= CMD_RST;
                chanRegs_ff[ch][IDX_INTDMA] <= INTDMA_RST;
                auxReg_ff[ch]               <= WREG_RST;
            end
            vectorReg_ff  <= WREG_RST;
            masterReg_ff  <= WREG_RST;
            ptr_ff        <= PTR_RST;
            rdData_ff     <= WREG_RST;
            rdValid_ff    <= 1'b0;
            dataWr_ff     <= 1'b0;
            dataWrChan_ff <= 1'b0;
            cmd_ff        <= '0;
        end else begin
            chanRegs_ff   <= nxt_chanRegs;
            auxReg_ff     <= nxt_auxReg;
            vectorReg_ff  <= nxt_vectorReg;
            masterReg_ff  <= nxt_masterReg;
            ptr_ff        <= nxt_ptr;
            rdData_ff     <= nxt_rdData;
            rdValid_ff    <= nxt_rdValid;
            dataWr_ff     <= nxt_dataWr;
            dataWrChan_ff <= nxt_dataWrChan;
            cmd_ff        <= nxt_cmd;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    assign hostRdData   = rdData_ff;
    assign hostRdValid  = rdValid_ff;
    assign regPointer   = ptr_ff;
    assign wrRegsA      = wrView[CH_A];
    assign wrRegsB      = wrView[CH_B];
    assign auxRegA      = auxReg_ff[CH_A];
    assign auxRegB      = auxReg_ff[CH_B];
    // Field view straight off the stored byte
    assign intDmaCtlA   = scpc_intdma_t'(chanRegs_ff[CH_A][IDX_INTDMA]);
    assign intDmaCtlB   = scpc_intdma_t'(chanRegs_ff[CH_B][IDX_INTDMA]);
    assign dataWrStrobe = dataWr_ff;
    assign dataWrChanA  = dataWrChan_ff;
    assign cmdA         = cmd_ff[CH_A];
    assign cmdB         = cmd_ff[CH_B];

endmodule
`default_nettype wire

//--- verif/scpc_regs_assertions.sv
// Concurrent checks on the register front end ports
`timescale 1ns/10ps
`default_nettype none
module scpc_regs_assertions
    import scpc_pkg::*;
(
    input wire logic             mclk,
    input wire logic             reset_n,
    input wire logic             hostWr,
    input wire logic             hostRd,
    input wire logic             hostChanA,
    input wire logic             hostDataSel,
    input wire logic [7:0]       hostWrData,
    input wire logic [3:0]       regPointer,
    input wire logic [15:0][7:0] wrRegsA,
    input wire scpc_intdma_t     intDmaCtlA,
    input wire scpc_cmd_t        cmdA,
    input wire scpc_cmd_t        cmdB
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Command byte taken: pointer at zero, control path
    sequence cmdWr; hostWr && !hostDataSel && regPointer == 4'h0; endsequence
    sequence cmdWrA; hostWr && !hostDataSel && regPointer == 4'h0 && hostChanA; endsequence
    chk_ptr_load: assert property (cmdWr |=> regPointer ==
        {$past(hostWrData[5:3]) == CMD_POINT_HI, $past(hostWrData[2:0])}) else $error("pointer load");
    chk_ptr_return: assert property ((hostWr || hostRd) && !hostDataSel && regPointer != 4'h0
        |=> regPointer == 4'h0) else $error("pointer not back at zero");
    chk_strobe_chan: assert property (cmdA != '0 |-> $past(hostWr) && $past(hostChanA))
        else $error("channel A strobe without channel A write");
    chk_crc_code: assert property (cmdWrA ##0 hostWrData[7:6] == CRC_TX_URUN
        |=> cmdA.txUnderrunRst && !cmdA.crcCheckRst) else $error("crc code 11");
    chk_null_code: assert property (cmdWr ##0 hostWrData[7:3] == 5'h0
        |=> cmdA == '0 && cmdB == '0) else $error("null command gave strobe");
    chk_ext_rearm: assert property (cmdWrA ##0 hostWrData[5:3] == CMD_EXT_RST
        |=> cmdA.extStatRst) else $error("ext status re-arm missing");
    chk_abort_mode: assert property (cmdWrA ##0 hostWrData[5:3] == CMD_ABORT
        |=> cmdA.sendAbort == ($past(wrRegsA[4][5:4]) == MODE_SDLC)) else $error("abort");
    chk_tx_pend: assert property (cmdWrA ##0 hostWrData[5:3] == CMD_TX_PEND
        |=> cmdA.txIntPendRst && !cmdA.rxIntNextEn) else $error("tx pending clear");
    chk_svc_reset: assert property (cmdWrA ##0 hostWrData[5:3] == CMD_SVC_RST
        |=> cmdA.highestSvcRst && !cmdA.errorRst) else $error("highest service reset");
    chk_intdma_view: assert property (hostWr && hostChanA && !hostDataSel
        && regPointer == 4'h1 |=> intDmaCtlA == $past(hostWrData)) else $error("int/dma write");
endmodule
`default_nettype wire

//--- verif/scpc_chan_model.sv
// Channel logic stand-in that supplies read register images
`timescale 1ns/10ps
`default_nettype none
module scpc_chan_model
    import scpc_pkg::*;
(
    output scpc_rdset_t rdSetA, // Channel A images
    output scpc_rdset_t rdSetB  // Channel B images
);
    // Each byte names channel and location, so any alias mix-up shows
    assign rdSetA = {8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA6, 8'hA7,
                     8'hA8, 8'hAA, 8'hAC, 8'hAD, 8'hAE, 8'hAF};
    assign rdSetB = {8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB6, 8'hB7,
                     8'hB8, 8'hBA, 8'hBC, 8'hBD, 8'hBE, 8'hBF};
endmodule
`default_nettype wire

//--- verif/scpc_regs_tb.sv
// Self-checking bench for the pointer and command front end
`timescale 1ns/10ps
`default_nettype none
module scpc_regs_tb
    import scpc_pkg::*;
;
    logic             mclk, reset_n, hostWr, hostRd, hostChanA, hostRdValid;
    logic             hostDataSel, dataWrStrobe, dataWrChanA;
    logic [7:0]       hostWrData, hostRdData, auxRegA;
    logic [3:0]       regPointer;
    logic [15:0][7:0] wrRegsA, wrRegsB;
    scpc_rdset_t      rdSetA, rdSetB;
    scpc_intdma_t     intDmaCtlA;
    scpc_cmd_t        cmdA, cmdB, expCmd;
    int               fails = 0, totalChecks = 0, cyc = 0;
    logic [2:0]       k;
    // Read locations and images: plain, status FIFO on, extended read on
    logic [7:0] locs [13] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0B, 8'h06,
                              8'h07, 8'h04, 8'h05, 8'h09, 8'h0B, 8'h0E};
    logic [7:0] exps [13] = '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hAD, 8'hAF, 8'hA6,
                              8'hA7, 8'h20, 8'h11, 8'h5A, 8'h33, 8'h40};
    // Front end under test
    scpc_regs scpc_regs_i (.mclk(mclk), .reset_n(reset_n), .hostWr(hostWr), .hostRd(hostRd),
        .hostChanA(hostChanA), .hostDataSel(hostDataSel), .hostWrData(hostWrData),
        .rdSetA(rdSetA), .rdSetB(rdSetB), .hostRdData(hostRdData), .hostRdValid(hostRdValid),
        .regPointer(regPointer), .wrRegsA(wrRegsA), .wrRegsB(wrRegsB), .auxRegA(auxRegA),
        .auxRegB(), .intDmaCtlA(intDmaCtlA), .intDmaCtlB(), .dataWrStrobe(dataWrStrobe),
        .dataWrChanA(dataWrChanA), .cmdA(cmdA), .cmdB(cmdB));
    scpc_chan_model scpc_chan_model_i (.rdSetA(rdSetA), .rdSetB(rdSetB));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic chk(input string n, input logic [8:0] s, input logic [8:0] e);
        totalChecks++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // One write; outputs settled on return
    task automatic wr(input logic c, input logic [7:0] d);
        @(posedge mclk);
        hostWr <= 1'b1;
        hostChanA <= c;
        hostWrData <= d;
        @(posedge mclk);
        hostWr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic c, input logic [7:0] e);
        @(posedge mclk);
        hostRd <= 1'b1;
        hostChanA <= c;
        @(posedge mclk);
        hostRd <= 1'b0;
        #1;
        chk("hostRdValid", hostRdValid, 1'b1);
        chk("hostRdData", hostRdData, e);
    endtask
    // Pointer byte {0000, high, low three} reaches any of the sixteen
    task automatic wloc(input logic c, input logic [3:0] l, input logic [7:0] d);
        wr(c, {4'h0, l});
        wr(c, d);
    endtask
    task automatic rloc(input logic c, input logic [3:0] l, input logic [7:0] e);
        wr(c, {4'h0, l});
        rd(c, e);
    endtask
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Hang guard, far past the run's length
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fails++;
            end_of_test();
        end
    end
    initial begin
        {reset_n, hostWr, hostRd, hostChanA, hostDataSel, hostWrData} = '0;
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        #1;
        chk("regPointer", regPointer, PTR_RST);
        chk("wrRegsA0", wrRegsA[0], CMD_RST);
        wloc(CH_A, IDX_WR3, 8'h5A);
        chk("wrRegsA3", wrRegsA[3], 8'h5A);
        chk("wrRegsB3", wrRegsB[3], 8'h00);
        wloc(CH_B, IDX_LOC11, 8'h77);
        chk("wrRegsB11", wrRegsB[11], 8'h77);
        for (int i = 0; i < 6; i++) rloc(CH_A, locs[i][3:0], exps[i]);
        rd(CH_B, 8'hB0);
        wloc(CH_A, IDX_EXTINT, 8'h05);
        for (int i = 6; i < 8; i++) rloc(CH_A, locs[i][3:0], exps[i]);
        wloc(CH_A, IDX_LOC7, 8'h40);
        chk("auxRegA", auxRegA, 8'h40);
        wloc(CH_A, IDX_WR4, 8'h20);
        wloc(CH_A, IDX_WR5, 8'h11);
        wloc(CH_A, IDX_WR10, 8'h33);
        for (int i = 8; i < 13; i++) rloc(CH_A, locs[i][3:0], exps[i]);
        // Every field and CRC code; 001 is the pointer code, covered above
        for (int i = 0; i < 8; i++) begin
            k = 3'(i);
            expCmd = '0;
            if (k >= 3'h2) expCmd[7 - k] = 1'b1;
            if (k[1:0] != 2'h0) expCmd[9 - k[1:0]] = 1'b1;
            if (k != 3'h1) begin
                wr(CH_A, {k[1:0], k, 3'h0});
                chk("cmdA", cmdA, expCmd);
                chk("cmdB", cmdB, '0);
            end
        end
        wr(CH_B, 8'h18);
        chk("cmdB", cmdB, '0);
        wloc(CH_A, IDX_INTDMA, 8'hA5);
        chk("intDmaCtlA", intDmaCtlA, 8'hA5);
        @(posedge mclk) hostDataSel <= 1'b1;
        wr(CH_A, 8'h3C);
        chk("dataWrStrobe", dataWrStrobe, 1'b1);
        chk("dataWrChanA", dataWrChanA, CH_A);
        end_of_test();
    end
endmodule
bind scpc_regs scpc_regs_assertions scpc_regs_assertions_i (.mclk(mclk), .reset_n(reset_n),
    .hostWr(hostWr), .hostRd(hostRd), .hostChanA(hostChanA), .hostDataSel(hostDataSel),
    .hostWrData(hostWrData), .regPointer(regPointer), .wrRegsA(wrRegsA),
    .intDmaCtlA(intDmaCtlA), .cmdA(cmdA), .cmdB(cmdB));
`default_nettype wire
